// ### sef_event_regs.svh
/*
  Constants for the sensor and actuator event payload formatter: reading-width
  codes, the actuator event category, byte counts and payload limits.
  Assumes it is included by bare name from the package and from design files.
*/
`ifndef SEF_EVENT_REGS_SVH
`define SEF_EVENT_REGS_SVH

// ==========================================================================
// reading-width codes, in the order the format list gives them
`define SEF_WIDTH_U8          8'h00
`define SEF_WIDTH_S8          8'h01
`define SEF_WIDTH_U16         8'h02
`define SEF_WIDTH_S16         8'h03
`define SEF_WIDTH_U32         8'h04
`define SEF_WIDTH_S32         8'h05

// ==========================================================================
// byte counts for each integer size
`define SEF_BYTES_NONE        3'h0
`define SEF_BYTES_1           3'h1
`define SEF_BYTES_2           3'h2
`define SEF_BYTES_4           3'h4

// ==========================================================================
// actuator event category: only operational-state change is defined
`define SEF_ACT_OPERATING_CHANGE 8'h00

// ==========================================================================
// payload buffer limits
`define SEF_MAX_BYTES         9
`define SEF_LEN_ONE           4'h1
`define SEF_LEN_TWO           4'h2
`define SEF_LEN_FIVE          4'h5
`define SEF_HDR_NUMERIC       4'h3
`define SEF_HDR_THRESHOLD     4'h1
`define SEF_IDX_ZERO          4'h0
`define SEF_IDX_ONE           4'h1

`endif

// ### sef_event_pkg.sv
/*
  Types for the sensor and actuator event payload formatter.
  Assumes sef_event_regs.svh sits in the same folder.
*/
`include "sef_event_regs.svh"

package sef_event_pkg;

  // ========================================================================
  // event kinds the formatter can build
  typedef enum logic [1:0] {
    SEF_KIND_NUMERIC   = 2'h0,
    SEF_KIND_SENSOR_OP = 2'h1,
    SEF_KIND_ACTUATOR  = 2'h2,
    SEF_KIND_THRESHOLD = 2'h3
  } sef_kind_type;

  // serializer states, one-hot
  typedef enum logic [1:0] {
    SEF_ST_IDLE = 2'b01,
    SEF_ST_SEND = 2'b10
  } sef_state_type;

  // payload bytes, element 0 goes out first
  typedef logic [`SEF_MAX_BYTES-1:0][7:0] sef_bytes_type;

  // bytes taken by a reading-width code; zero marks an undefined code
  function automatic logic [2:0] sef_width_bytes(input logic [7:0] code);
    case (code)
      `SEF_WIDTH_U8, `SEF_WIDTH_S8:   sef_width_bytes = `SEF_BYTES_1;
      `SEF_WIDTH_U16, `SEF_WIDTH_S16: sef_width_bytes = `SEF_BYTES_2;
      `SEF_WIDTH_U32, `SEF_WIDTH_S32: sef_width_bytes = `SEF_BYTES_4;
      default:                        sef_width_bytes = `SEF_BYTES_NONE;
    endcase
  endfunction

endpackage

// ### sef_payload_if.sv
/*
  Carries a built payload from the field builder to the serializer.
  Assumes both ends run on the same clock; the content is combinational.
*/
`timescale 1ns/1ns

interface sef_payload_if;
  import sef_event_pkg::*;

  sef_bytes_type bytes;     // payload, element 0 first
  logic [3:0]    len;       // number of valid bytes
  logic          bad_width; // reading-width code undefined

  modport builder (output bytes, output len, output bad_width);
  modport framer  (input bytes, input len, input bad_width);
endinterface

// ### sef_field_builder.sv
/*
  Builds the byte image of one event payload from its fields.
  Assumes inputs are stable for the cycle in which the framer samples them.
*/
`timescale 1ns/1ns
`include "sef_event_regs.svh"

module sef_field_builder (
  input  wire sef_event_pkg::sef_kind_type kind,
  input  wire logic [7:0]                  current_state_code,
  input  wire logic                        prior_known,
  input  wire logic [7:0]                  prior_code,
  input  wire logic [7:0]                  reading_width_code,
  input  wire logic [31:0]                 current_value,
  input  wire logic [31:0]                 hysteresis_value,
  input  wire logic [15:0]                 actuator_identifier,
  sef_payload_if.builder                   pl
);
  import sef_event_pkg::*;

  logic [2:0] vbytes;
  logic [7:0] prior_sel;

  // ========================================================================
  // field placement
  // an unknown prior code repeats the current one, in every kind that carries a prior byte (all but threshold)
  always_comb begin
    vbytes       = sef_width_bytes(reading_width_code);
    prior_sel    = prior_known ? prior_code : current_state_code;
    pl.bytes     = '0;
    pl.len       = `SEF_LEN_ONE;
    pl.bad_width = 1'b0;
    case (kind)
      SEF_KIND_NUMERIC: begin
        pl.bytes[0] = current_state_code;
        pl.bytes[1] = prior_sel;
        pl.bytes[2] = reading_width_code;
        for (int i = 0; i < 4; i++) begin
          // value bytes low first, exactly as many as the code says
          if (3'(i) < vbytes) begin
            pl.bytes[3 + i] = current_value[8*i +: 8];
          end
        end
        pl.len       = `SEF_HDR_NUMERIC + 4'(vbytes);
        pl.bad_width = (vbytes == `SEF_BYTES_NONE);
      end
      SEF_KIND_SENSOR_OP: begin
        pl.bytes[0] = current_state_code;
        pl.bytes[1] = prior_sel;
        pl.len      = `SEF_LEN_TWO;
      end
      SEF_KIND_ACTUATOR: begin
        pl.bytes[0] = actuator_identifier[7:0];
        pl.bytes[1] = actuator_identifier[15:8];
        pl.bytes[2] = `SEF_ACT_OPERATING_CHANGE;
        pl.bytes[3] = current_state_code;
        pl.bytes[4] = prior_sel;
        pl.len      = `SEF_LEN_FIVE;
      end
      SEF_KIND_THRESHOLD: begin
        // threshold and hysteresis share the sensor's reading format
        pl.bytes[0] = reading_width_code;
        for (int i = 0; i < 4; i++) begin
          if (3'(i) < vbytes) begin
            pl.bytes[1 + i] = current_value[8*i +: 8];
            pl.bytes[4'(1 + i) + 4'(vbytes)] = hysteresis_value[8*i +: 8];
          end
        end
        pl.len       = `SEF_HDR_THRESHOLD + 4'({vbytes, 1'b0});
        pl.bad_width = (vbytes == `SEF_BYTES_NONE);
      end
      default: begin
        pl.bad_width = 1'b1;
      end
    endcase
  end

endmodule

// ### sef_event_formatter.sv
/*
  Sensor and actuator event payload formatter: takes one event's fields,
  builds its payload and sends it one byte a cycle on a valid/ready stream.
  Assumes every input comes from logic on ref_clk; no pin reaches it directly.
*/
`timescale 1ns/1ns
`include "sef_event_regs.svh"

module sef_event_formatter (
  input  wire logic                        ref_clk,
  input  wire logic                        srst,
  // event request
  input  wire logic                        start,
  input  wire sef_event_pkg::sef_kind_type kind,
  input  wire logic [7:0]                  current_state_code,
  input  wire logic                        prior_known,
  input  wire logic [7:0]                  prior_code,
  input  wire logic [7:0]                  reading_width_code,
  input  wire logic [31:0]                 current_value,
  input  wire logic [31:0]                 hysteresis_value,
  input  wire logic [15:0]                 actuator_identifier,
  output logic                             start_ready,
  output logic                             width_error,
  // byte stream toward the management controller
  output logic                             out_valid,
  output logic [7:0]                       out_data,
  output logic                             out_last,
  input  wire logic                        out_ready
);
  import sef_event_pkg::*;

  sef_payload_if pl ();

  sef_state_type state;
  sef_state_type next_state;
  sef_bytes_type held;
  sef_bytes_type next_held;
  logic [3:0]    len;
  logic [3:0]    next_len;
  logic [3:0]    idx;
  logic [3:0]    next_idx;
  logic          next_start_ready;
  logic          next_width_error;
  logic          next_out_valid;
  logic [7:0]    next_out_data;
  logic          next_out_last;
  logic          accept;           // a well-formed event is taken at this edge
  logic          refuse;           // a numeric or threshold event with an undefined width code is dropped
  logic          advance;          // the receiver takes a byte that is not the last
  logic          finish;           // the receiver takes the last byte
  logic          stray;            // state holds an illegal one-hot code

  // ==========================================================================
  // payload builder
  // byte images, first byte out first, multi-byte fields low byte first:
  //   numeric   : current, prior, width code, 1/2/4 value bytes
  //   sensor op : new condition, prior condition
  //   actuator  : identifier low, identifier high, category, new, prior
  //   threshold : width code, threshold bytes, hysteresis bytes
  // the builder is purely combinational; its image is only trusted at the
  // edge that takes a start, when the request fields are sampled
  sef_field_builder u_builder (
    .kind                (kind),
    .current_state_code  (current_state_code),
    .prior_known         (prior_known),
    .prior_code          (prior_code),
    .reading_width_code  (reading_width_code),
    .current_value       (current_value),
    .hysteresis_value    (hysteresis_value),
    .actuator_identifier (actuator_identifier),
    .pl                  (pl)
  );

  // ==========================================================================
  // handshake strobes
  // every register group below steers on these, so the two ends of a transfer
  // are decoded once and cannot drift apart
  // timing: a start taken at one edge shows its first byte after that edge;
  // a stall of out_ready simply keeps the current byte on the wires
  always_comb begin
    accept  = 1'b0;
    refuse  = 1'b0;
    advance = 1'b0;
    finish  = 1'b0;
    stray   = 1'b0;
    case (state)
      SEF_ST_IDLE: begin
        // a numeric or threshold event with an undefined width code is dropped, a receiver could not parse it
        accept = start && start_ready && !pl.bad_width;
        refuse = start && start_ready && pl.bad_width;
      end
      SEF_ST_SEND: begin
        advance = out_ready && !out_last;
        finish  = out_ready && out_last;
      end
      default: begin
        // illegal one-hot codes fall back to idle
        stray = 1'b1;
      end
    endcase
  end

  // ==========================================================================
  // control next state
  // the width code is ignored for kinds that carry no reading
  always_comb begin
    next_state       = state;
    next_len         = len;
    next_idx         = idx;
    next_start_ready = start_ready;
    next_width_error = refuse; // one-cycle pulse, nothing is sent
    case (state)
      SEF_ST_IDLE: begin
        if (accept) begin
          next_len         = pl.len;
          next_idx         = `SEF_IDX_ONE;
          next_start_ready = 1'b0;
          next_state       = SEF_ST_SEND;
        end
      end
      SEF_ST_SEND: begin
        if (finish) begin
          // a new event is taken at the edge after the last byte leaves
          next_start_ready = 1'b1;
          next_state       = SEF_ST_IDLE;
        end else if (advance) begin
          next_idx = idx + `SEF_IDX_ONE;
        end
      end
      default: begin
        next_state       = SEF_ST_IDLE;
        next_start_ready = 1'b1;
      end
    endcase
  end

  // ==========================================================================
  // control registers
  // len and idx only matter while sending
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state       <= SEF_ST_IDLE;
      len         <= `SEF_IDX_ZERO;
      idx         <= `SEF_IDX_ZERO;
      start_ready <= 1'b1;
      width_error <= 1'b0;
    end else begin
      state       <= next_state;
      len         <= next_len;
      idx         <= next_idx;
      start_ready <= next_start_ready;
      width_error <= next_width_error;
    end
  end

  // ==========================================================================
  // payload store next state
  // the payload is copied whole on acceptance so the requester may move on;
  // storage is flip-flops, read by idx while sending
  always_comb begin
    next_held = held;
    if (accept) begin
      next_held = pl.bytes;
    end
  end

  // payload store registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      held <= '0;
    end else begin
      held <= next_held;
    end
  end

  // ==========================================================================
  // stream output next state
  // fields leave in listed order, each held until the receiver takes it;
  // out_data keeps its last byte when idle, only out_valid qualifies it
  always_comb begin
    next_out_valid = out_valid;
    next_out_data  = out_data;
    next_out_last  = out_last;
    if (accept) begin
      next_out_data  = pl.bytes[`SEF_IDX_ZERO];
      next_out_valid = 1'b1;
      next_out_last  = (pl.len == `SEF_LEN_ONE);
    end else if (advance) begin
      next_out_data = held[idx];
      next_out_last = (idx == len - `SEF_IDX_ONE);
    end else if (finish || stray) begin
      next_out_valid = 1'b0;
      next_out_last  = 1'b0;
    end
  end

  // stream output registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      out_valid <= 1'b0;
      out_data  <= 8'h00;
      out_last  <= 1'b0;
    end else begin
      out_valid <= next_out_valid;
      out_data  <= next_out_data;
      out_last  <= next_out_last;
    end
  end

endmodule

// ### sef_fmt_chk.sv
/*
  Port checker for the event payload formatter.
  Assumes binding to sef_event_formatter; one clock, srst synchronous.
*/
`timescale 1ns/1ns
`include "sef_event_regs.svh"

module sef_fmt_chk (
  input wire logic                        ref_clk,
  input wire logic                        srst,
  input wire logic                        start,
  input wire sef_event_pkg::sef_kind_type kind,
  input wire logic [7:0]                  current_state_code,
  input wire logic                        prior_known,
  input wire logic [7:0]                  reading_width_code,
  input wire logic [15:0]                 actuator_identifier,
  input wire logic                        start_ready,
  input wire logic                        width_error,
  input wire logic                        out_valid,
  input wire logic [7:0]                  out_data,
  input wire logic                        out_last,
  input wire logic                        out_ready
);
  import sef_event_pkg::*;
  // ==========================================================
  // properties
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  // width code matters only for kinds carrying a reading
  logic bad;
  assign bad = (kind == SEF_KIND_NUMERIC || kind == SEF_KIND_THRESHOLD) && reading_width_code > `SEF_WIDTH_S32;
  sequence s_take; start && start_ready; endsequence
  sequence s_op_unk; s_take ##0 kind == SEF_KIND_SENSOR_OP && !prior_known ##1 out_valid && out_ready; endsequence
  sequence s_num_unk;
    s_take ##0 kind == SEF_KIND_NUMERIC && !prior_known && !bad ##1 out_valid && out_ready;
  endsequence
  property p_refuse; s_take ##0 bad |=> width_error && !out_valid && start_ready; endproperty
  property p_launch; s_take ##0 !bad |=> out_valid && !start_ready && !width_error; endproperty
  property p_hold; out_valid && !out_ready |=> out_valid && $stable(out_data) && $stable(out_last); endproperty
  property p_end; out_valid && out_ready && out_last |=> !out_valid && start_ready; endproperty
  property p_busy; out_valid |-> !start_ready; endproperty
  property p_op_new; s_take ##0 kind == SEF_KIND_SENSOR_OP |=> out_data == $past(current_state_code); endproperty
  property p_op_unk; s_op_unk |=> out_data == $past(out_data); endproperty
  property p_num_unk; s_num_unk |=> out_data == $past(out_data); endproperty
  property p_act_id;
    s_take ##0 kind == SEF_KIND_ACTUATOR |=> out_data == $past(actuator_identifier[7:0]);
  endproperty
  a_refuse: assert property (p_refuse) else $error("bad width not refused");
  a_launch: assert property (p_launch) else $error("accepted event not sent");
  a_hold: assert property (p_hold) else $error("byte changed in stall");
  a_end: assert property (p_end) else $error("no idle after last");
  a_busy: assert property (p_busy) else $error("ready while sending");
  a_op_new: assert property (p_op_new) else $error("wrong new condition");
  a_op_unk: assert property (p_op_unk) else $error("prior not new");
  a_num_unk: assert property (p_num_unk) else $error("prior not current");
  a_act_id: assert property (p_act_id) else $error("wrong id low byte");
endmodule

bind sef_event_formatter sef_fmt_chk u_chk (.ref_clk, .srst, .start, .kind, .current_state_code, .prior_known,
  .reading_width_code, .actuator_identifier, .start_ready, .width_error, .out_valid, .out_data, .out_last,
  .out_ready);

// ### sef_mc_model.sv
/*
  Management controller model: takes payload bytes, may stall.
  Assumes the bench clears rx and last_at between events.
*/
`timescale 1ns/1ns

module sef_mc_model (
  input  wire logic       ref_clk,
  input  wire logic       srst,
  input  wire logic       slow,
  input  wire logic       out_valid,
  input  wire logic [7:0] out_data,
  input  wire logic       out_last,
  output logic            out_ready
);
  // ==========================================================
  // receiver
  logic [7:0] rx[$];
  int         last_at = -1;
  initial out_ready = 1'b1;
  // bytes kept in arrival order; the bench compares them one by one against its expected queue
  always @(posedge ref_clk) begin
    if (out_valid && out_ready) begin
      if (out_last) last_at = rx.size();
      rx.push_back(out_data);
    end
    out_ready <= srst || !slow || !out_ready; // slow mode stalls every other cycle
  end
endmodule

// ### testbench.sv
/*
  Self-checking bench for the event payload formatter.
  Assumes the checker binds itself and the receiver model sits beside.
*/
`timescale 1ns/1ns

module testbench;
  import sef_event_pkg::*;
  // ==========================================================
  // stimulus and wires
  logic         ref_clk = 0, srst = 1, start = 0, prior_known = 0, slow = 0;
  sef_kind_type kind = SEF_KIND_NUMERIC;
  logic [7:0]   current_state_code = 0, prior_code = 0, reading_width_code = 0;
  logic [31:0]  current_value = 0, hysteresis_value = 0;
  logic [15:0]  actuator_identifier = 0;
  logic         start_ready, width_error, out_valid, out_last, out_ready;
  logic [7:0]   out_data, exp_q[$];
  int           error_cnt = 0, n_tests = 0;
  always #4 ref_clk = ~ref_clk;
  sef_event_formatter u_dut (.ref_clk, .srst, .start, .kind, .current_state_code, .prior_known, .prior_code,
    .reading_width_code, .current_value, .hysteresis_value, .actuator_identifier, .start_ready, .width_error,
    .out_valid, .out_data, .out_last, .out_ready);
  sef_mc_model u_mc (.ref_clk, .srst, .slow, .out_valid, .out_data, .out_last, .out_ready);

  // ==========================================================
  // helpers
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  function automatic int nb(logic [7:0] c);
    return c < 2 ? 1 : (c < 4 ? 2 : 4);
  endfunction
  task automatic push_val(logic [31:0] v, int n);
    for (int i = 0; i < n; i++) exp_q.push_back(v[8*i+:8]); // low byte first
  endtask
  // one event end to end, then compare against exp_q
  task automatic run(sef_kind_type k, logic [7:0] c, logic pk, logic [7:0] pc, logic [7:0] wc,
                     logic [31:0] v, logic [31:0] h, logic [15:0] id);
    int i;
    u_mc.rx.delete();
    u_mc.last_at = -1;
    @(posedge ref_clk);
    kind <= k; current_state_code <= c; prior_known <= pk; prior_code <= pc;
    reading_width_code <= wc; current_value <= v; hysteresis_value <= h; actuator_identifier <= id;
    start <= 1;
    @(posedge ref_clk);
    start <= 0;
    for (i = 0; i < 60 && u_mc.rx.size() < exp_q.size(); i++) @(posedge ref_clk);
    if (i == 60) begin
      error_cnt++;
      stop_test();
    end
    repeat (2) @(posedge ref_clk);
    #1;
    chk("count", exp_q.size(), u_mc.rx.size());
    chk("last", exp_q.size() - 1, u_mc.last_at);
    chk("idle", 1, start_ready & ~out_valid);
    foreach (exp_q[j]) chk("byte", exp_q[j], u_mc.rx[j]);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_numeric();
    for (int w = 0; w < 6; w++) begin
      slow = w[0];
      exp_q = {8'h2A, (w == 5) ? 8'h11 : 8'h2A, 8'(w)};
      push_val(32'hF1E2D3C4, nb(w));
      run(SEF_KIND_NUMERIC, 8'h2A, w == 5, 8'h11, 8'(w), 32'hF1E2D3C4, 0, 0);
    end
    $display("numeric done");
  endtask
  task automatic t_ops();
    for (int p = 0; p < 2; p++) begin
      slow = p[0]; // no stalls while the prior is unknown, so the first byte is taken at once
      exp_q = {8'h05, p ? 8'h03 : 8'h05};
      run(SEF_KIND_SENSOR_OP, 8'h05, p, 8'h03, 8'hFF, 0, 0, 0);
      exp_q = {8'hEF, 8'hBE, 8'h00, 8'h07, p ? 8'h01 : 8'h07};
      run(SEF_KIND_ACTUATOR, 8'h07, p, 8'h01, 8'hFF, 0, 0, 16'hBEEF);
    end
    $display("operating change done");
  endtask
  task automatic t_threshold();
    for (int w = 1; w < 6; w += 2) begin
      exp_q = {8'(w)};
      push_val(32'hFFFFFF80, nb(w));
      push_val(32'h00000102, nb(w));
      run(SEF_KIND_THRESHOLD, 0, 0, 0, 8'(w), 32'hFFFFFF80, 32'h00000102, 0);
    end
    $display("threshold done");
  endtask
  task automatic t_bad();
    for (int k = 0; k < 2; k++) begin
      @(posedge ref_clk);
      kind <= k ? SEF_KIND_THRESHOLD : SEF_KIND_NUMERIC;
      reading_width_code <= k ? 8'hFF : 8'h06;
      start <= 1;
      @(posedge ref_clk);
      start <= 0;
      #1;
      chk("refuse", 3'b101, {width_error, out_valid, start_ready});
      @(posedge ref_clk);
      #1;
      chk("pulse", 2'b00, {width_error, out_valid});
    end
    $display("bad width done");
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (3) @(posedge ref_clk);
    srst <= 0;
    #1;
    chk("reset", 5'b10000, {start_ready, width_error, out_valid, out_last, |out_data});
    t_numeric();
    t_ops();
    t_threshold();
    t_bad();
    stop_test();
  end
endmodule
